// *** sfc_pkg.sv ***
// Package for the serial frame format block: offsets, field positions,
// reset values, prescale codes and state encodings.
// Assumes a single 10 MHz core clock and a byte-wide register port.
package sfc_pkg;
  // Register offsets
  localparam logic [2:0] ADR_FMT = 3'h0;
  localparam logic [2:0] ADR_TXH = 3'h1;
  localparam logic [2:0] ADR_CTL = 3'h2;
  localparam logic [2:0] ADR_STA = 3'h3;
  localparam logic [2:0] ADR_RXD = 3'h4;
  // Format register fields
  localparam int FB_SYNC = 7;
  localparam int FB_SEVEN = 6;
  localparam int FB_PAR = 5;
  localparam int FB_ODD = 4;
  localparam int FB_TWO = 3;
  localparam int FB_MP = 2;
  // Control register fields
  localparam int CB_TXGO = 0;
  localparam int CB_RXGO = 1;
  localparam int CB_MPB = 2;
  // Status register fields
  localparam int SB_TXE = 0;
  localparam int SB_TEND = 1;
  localparam int SB_RXF = 2;
  localparam int SB_PER = 3;
  localparam int SB_FER = 4;
  localparam int SB_MPB = 5;
  // Reset values
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [7:0] TXH_RST = 8'hff;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] RXD_RST = 8'h00;
  // Prescale divide values per code; code 3 divides by 64
  localparam logic [6:0] DIV_C0 = 7'h01;
  localparam logic [6:0] DIV_C1 = 7'h04;
  localparam logic [6:0] DIV_C2 = 7'h10;
  localparam logic [6:0] DIV_C3 = 7'h40;
  // Default prescaled ticks per bit
  localparam logic [7:0] BIT_TICKS_DEF = 8'h10;
  // Transmit states
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
    TX_PAR = 5'h08, TX_STOP = 5'h10
  } sfc_tx_type;
  // Receive states
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
    RX_PAR = 5'h08, RX_STOP = 5'h10
  } sfc_rx_type;
endpackage : sfc_pkg

// *** sfc_prescale.sv ***
// Baud generator input prescaler: one-cycle tick every 1, 4, 16 or 64 clocks.
// Assumes the select code comes from the format register.
module sfc_prescale (
  input wire logic core_clk_in, // Core clock
  input wire logic reset_in, // Synchronous reset
  input wire logic [1:0] sel_in, // Prescale code
  output logic tick_out // Prescaled tick pulse
);
  import sfc_pkg::*;

  logic [6:0] cnt_q; // Divider count
  logic [6:0] cnt_d; // Next divider count
  logic [6:0] div; // Selected divide value

  // Code to divide value
  function automatic logic [6:0] div_of(input logic [1:0] code);
    case (code)
      2'h0: div_of = DIV_C0;
      2'h1: div_of = DIV_C1;
      2'h2: div_of = DIV_C2;
      default: div_of = DIV_C3;
    endcase
  endfunction : div_of

  // Next count and tick
  always_comb begin
    div = div_of(sel_in);
    tick_out = (cnt_q >= div - 7'h01);
    cnt_d = tick_out ? 7'h00 : cnt_q + 7'h01;
  end

  // Count register
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : sfc_prescale

// *** sfc_serial.sv ***
// Serial port core: format register, transmitter and receiver.
// Assumes inputs synchronous to core_clk_in; rxd_in already synchronised.
module sfc_serial #(
  parameter logic [7:0] BIT_TICKS = sfc_pkg::BIT_TICKS_DEF // Ticks per bit
) (
  input wire logic core_clk_in, // Core clock, 10 MHz
  input wire logic reset_in, // Synchronous reset, high
  input wire logic lowpower_in, // Low-power mode entry, high
  input wire logic [2:0] addr_in, // Register address
  input wire logic [7:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [7:0] rdata_out, // Read data, cycle after strobe
  output logic txd_out, // Serial transmit line
  input wire logic rxd_in, // Serial receive line
  output logic sclk_out, // Serial clock, sync mode
  output logic sclk_oe_out // Serial clock drive enable
);
  import sfc_pkg::*;

  localparam logic [7:0] HALF = {1'b0, BIT_TICKS[7:1]}; // Mid-bit point

  logic rst; // Reset or low-power clear
  logic tick; // Prescaled tick
  logic [7:0] fmt_q, fmt_d; // Format register
  logic [7:0] txh_q, txh_d; // Transmit holding register
  logic [7:0] ctl_q, ctl_d; // Control register
  logic [7:0] rxd_q, rxd_d; // Receive data register
  logic [7:0] rdata_q, rdata_d; // Read data register
  logic txe_q, txe_d; // Holding register empty
  logic rxf_q, rxf_d; // Receive data full
  logic per_q, per_d; // Parity error
  logic fer_q, fer_d; // Framing error
  logic mpr_q, mpr_d; // Received multiprocessor bit
  logic is_sync, seven, par_en, mp_en, odd, two; // Effective format
  logic wr_fmt, wr_txh, wr_ctl, wr_sta; // Write decodes
  sfc_tx_type tx_q, tx_d; // Transmit state
  logic [7:0] tcnt_q, tcnt_d; // Transmit tick count
  logic [7:0] tsh_q, tsh_d; // Transmit shifter
  logic [2:0] tbit_q, tbit_d; // Transmit bit index
  logic tpar_q, tpar_d; // Transmit parity or MP bit
  logic tstop_q, tstop_d; // Second stop bit pending
  logic take; // Transmitter takes holding register
  logic t_end; // Transmit bit end
  sfc_rx_type rx_q, rx_d; // Receive state
  logic [7:0] rcnt_q, rcnt_d; // Receive tick count
  logic [7:0] rsh_q, rsh_d; // Receive shifter
  logic [2:0] rbit_q, rbit_d; // Receive bit index
  logic rpar_q, rpar_d; // Received parity or MP bit
  logic r_end, r_mid; // Receive timing points
  logic samp; // Receive data sample point
  logic sync_rise; // Serial clock rising point
  logic done; // Character complete
  logic [7:0] rword; // Aligned received character
  logic perr, ferr; // Errors of the finished character

  // Parity of the active data bits
  function automatic logic par_of(input logic [7:0] d, input logic sev);
    par_of = sev ? ^d[6:0] : ^d;
  endfunction : par_of

  // Last data bit index for the length
  function automatic logic [2:0] last_of(input logic sev);
    last_of = sev ? 3'h6 : 3'h7;
  endfunction : last_of

  assign rst = reset_in | lowpower_in;

  sfc_prescale u_pre (
    .core_clk_in(core_clk_in),
    .reset_in(rst),
    .sel_in(fmt_q[1:0]),
    .tick_out(tick)
  );

  // Effective format decode
  always_comb begin
    is_sync = fmt_q[FB_SYNC];
    seven = !is_sync && fmt_q[FB_SEVEN];
    mp_en = !is_sync && fmt_q[FB_MP];
    par_en = !is_sync && !mp_en && fmt_q[FB_PAR];
    odd = fmt_q[FB_ODD];
    two = !is_sync && fmt_q[FB_TWO];
  end

  // Register writes and read mux
  always_comb begin
    wr_fmt = wr_in && addr_in == ADR_FMT;
    wr_txh = wr_in && addr_in == ADR_TXH;
    wr_ctl = wr_in && addr_in == ADR_CTL;
    wr_sta = wr_in && addr_in == ADR_STA;
    fmt_d = wr_fmt ? wdata_in : fmt_q;
    txh_d = wr_txh ? wdata_in : txh_q;
    ctl_d = wr_ctl ? wdata_in : ctl_q;
    rdata_d = 8'h00;
    if (rd_in) begin
      case (addr_in)
        ADR_FMT: rdata_d = fmt_q;
        ADR_TXH: rdata_d = txh_q;
        ADR_CTL: rdata_d = ctl_q;
        ADR_STA: begin
          rdata_d[SB_TXE] = txe_q;
          rdata_d[SB_TEND] = txe_q && tx_q == TX_IDLE;
          rdata_d[SB_RXF] = rxf_q;
          rdata_d[SB_PER] = per_q;
          rdata_d[SB_FER] = fer_q;
          rdata_d[SB_MPB] = mpr_q;
        end
        ADR_RXD: rdata_d = rxd_q;
        default: rdata_d = 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // Transmitter next state
  always_comb begin
    tx_d = tx_q;
    tcnt_d = tcnt_q;
    tsh_d = tsh_q;
    tbit_d = tbit_q;
    tpar_d = tpar_q;
    tstop_d = tstop_q;
    take = 1'b0;
    txd_out = 1'b1;
    t_end = tick && tcnt_q >= BIT_TICKS - 8'h01;
    if (tick) begin
      tcnt_d = t_end ? 8'h00 : tcnt_q + 8'h01;
    end
    case (tx_q)
      TX_IDLE: begin
        tcnt_d = 8'h00;
        if (ctl_q[CB_TXGO] && !txe_q) begin
          take = 1'b1;
          tsh_d = seven ? {1'b0, txh_q[6:0]} : txh_q;
          tbit_d = 3'h0;
          tstop_d = 1'b0;
          // Parity sense: odd inverts the even bit
          tpar_d = mp_en ? ctl_q[CB_MPB] : (par_of(txh_q, seven) ^ odd);
          tx_d = is_sync ? TX_DATA : TX_START;
        end
      end
      TX_START: begin
        txd_out = 1'b0; // Low start bit
        if (t_end) begin
          tx_d = TX_DATA;
        end
      end
      TX_DATA: begin
        txd_out = tsh_q[0]; // LSB first
        if (t_end) begin
          tsh_d = {1'b0, tsh_q[7:1]};
          tbit_d = tbit_q + 3'h1;
          if (tbit_q == last_of(seven)) begin
            if (is_sync) begin
              tx_d = TX_IDLE; // No stop bits
            end else if (par_en || mp_en) begin
              tx_d = TX_PAR;
            end else begin
              tx_d = TX_STOP;
            end
          end
        end
      end
      TX_PAR: begin
        txd_out = tpar_q;
        if (t_end) begin
          tx_d = TX_STOP;
        end
      end
      TX_STOP: begin
        txd_out = 1'b1; // High stop bit
        if (t_end) begin
          if (two && !tstop_q) begin
            tstop_d = 1'b1;
          end else begin
            tx_d = TX_IDLE;
          end
        end
      end
      default: tx_d = TX_IDLE;
    endcase
    // Serial clock: low first half, high second half of a data bit
    sclk_oe_out = is_sync;
    sclk_out = !(is_sync && tx_q == TX_DATA && tcnt_q < HALF);
    sync_rise = is_sync && tx_q == TX_DATA && tick && tcnt_q == HALF - 8'h01;
  end

  // Receiver next state
  always_comb begin
    rx_d = rx_q;
    rcnt_d = rcnt_q;
    rsh_d = rsh_q;
    rbit_d = rbit_q;
    rpar_d = rpar_q;
    done = 1'b0;
    ferr = 1'b0;
    r_end = tick && rcnt_q >= BIT_TICKS - 8'h01;
    r_mid = tick && rcnt_q == HALF - 8'h01;
    samp = is_sync ? sync_rise : r_end;
    if (tick) begin
      rcnt_d = r_end ? 8'h00 : rcnt_q + 8'h01;
    end
    rword = seven ? {1'b0, rsh_q[7:1]} : rsh_q;
    // Error when ones count misses the chosen sense
    perr = par_en && ((par_of(rword, 1'b0) ^ rpar_q) != odd);
    case (rx_q)
      RX_IDLE: begin
        rcnt_d = 8'h00;
        rbit_d = 3'h0;
        if (ctl_q[CB_RXGO]) begin
          if (is_sync) begin
            if (tx_q == TX_DATA && tbit_q == 3'h0 && tcnt_q == 8'h00) begin
              rx_d = RX_DATA;
            end
          end else if (!rxd_in) begin
            rx_d = RX_START;
          end
        end
      end
      RX_START: begin
        if (r_mid) begin
          rcnt_d = 8'h00; // Realign to mid-bit
          rx_d = rxd_in ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (samp) begin
          rsh_d = {rxd_in, rsh_q[7:1]};
          rbit_d = rbit_q + 3'h1;
          if (rbit_q == last_of(seven)) begin
            if (is_sync) begin
              rx_d = RX_IDLE;
            end else if (par_en || mp_en) begin
              rx_d = RX_PAR;
            end else begin
              rx_d = RX_STOP;
            end
          end
        end
      end
      RX_PAR: begin
        if (r_end) begin
          rpar_d = rxd_in;
          rx_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (r_end) begin
          // Only the first stop bit is checked
          done = 1'b1;
          ferr = !rxd_in;
          rx_d = RX_IDLE; // A low next bit starts a new character
        end
      end
      default: rx_d = RX_IDLE;
    endcase
    // Synchronous character ends on its eighth sample
    if (rx_q == RX_DATA && is_sync && samp && rbit_q == 3'h7) begin
      done = 1'b1;
    end
  end

  // Status flags; hardware set wins over software clear
  always_comb begin
    rxd_d = done ? (is_sync ? rsh_d : rword) : rxd_q;
    rxf_d = done || (rxf_q && !(wr_sta && wdata_in[SB_RXF]));
    per_d = (done && !is_sync && perr) || (per_q && !(wr_sta && wdata_in[SB_PER]));
    fer_d = (done && ferr) || (fer_q && !(wr_sta && wdata_in[SB_FER]));
    mpr_d = (done && mp_en) ? rpar_q : mpr_q;
    // Empty forced while transmit is off; a new write beats a take
    if (!ctl_q[CB_TXGO]) begin
      txe_d = 1'b1;
    end else if (wr_txh) begin
      txe_d = 1'b0;
    end else begin
      txe_d = txe_q || take;
    end
  end

  // Register file and status flops
  always_ff @(posedge core_clk_in) begin
    if (rst) begin
      fmt_q <= FMT_RST;
      txh_q <= TXH_RST;
      ctl_q <= CTL_RST;
      rxd_q <= RXD_RST;
      rdata_q <= 8'h00;
      txe_q <= 1'b1;
      rxf_q <= 1'b0;
      per_q <= 1'b0;
      fer_q <= 1'b0;
      mpr_q <= 1'b0;
    end else begin
      fmt_q <= fmt_d;
      txh_q <= txh_d;
      ctl_q <= ctl_d;
      rxd_q <= rxd_d;
      rdata_q <= rdata_d;
      txe_q <= txe_d;
      rxf_q <= rxf_d;
      per_q <= per_d;
      fer_q <= fer_d;
      mpr_q <= mpr_d;
    end
  end

  // Transmitter flops
  always_ff @(posedge core_clk_in) begin
    if (rst) begin
      tx_q <= TX_IDLE;
      tcnt_q <= 8'h00;
      tsh_q <= 8'h00;
      tbit_q <= 3'h0;
      tpar_q <= 1'b0;
      tstop_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      tcnt_q <= tcnt_d;
      tsh_q <= tsh_d;
      tbit_q <= tbit_d;
      tpar_q <= tpar_d;
      tstop_q <= tstop_d;
    end
  end

  // Receiver flops
  always_ff @(posedge core_clk_in) begin
    if (rst) begin
      rx_q <= RX_IDLE;
      rcnt_q <= 8'h00;
      rsh_q <= 8'h00;
      rbit_q <= 3'h0;
      rpar_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      rcnt_q <= rcnt_d;
      rsh_q <= rsh_d;
      rbit_q <= rbit_d;
      rpar_q <= rpar_d;
    end
  end

  assign rdata_out = rdata_q;
endmodule : sfc_serial

// *** sfc_serial_sva.sv ***
// Checker for the serial format block, watching only top-level ports.
// Assumes it is bound to sfc_serial and shares its clock and reset.
module sfc_serial_chk
  import sfc_pkg::*;
#(
  parameter logic [7:0] BIT_TICKS = BIT_TICKS_DEF // Ticks per bit
) (
  input wire logic core_clk_in, // Core clock
  input wire logic reset_in, // Synchronous reset
  input wire logic lowpower_in, // Low-power entry
  input wire logic [2:0] addr_in, // Register address
  input wire logic [7:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  input wire logic [7:0] rdata_out, // Read data
  input wire logic txd_out, // Serial out
  input wire logic rxd_in, // Serial in
  input wire logic sclk_out, // Serial clock
  input wire logic sclk_oe_out // Serial clock enable
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // Format register write and read cycles, and a quiet cycle
  sequence s_fmt_wr;
    wr_in && addr_in == ADR_FMT && !lowpower_in;
  endsequence
  sequence s_fmt_rd;
    rd_in && !wr_in && addr_in == ADR_FMT && !lowpower_in;
  endsequence
  sequence s_quiet;
    !wr_in && !lowpower_in;
  endsequence
  chk_rdata_idle_zero: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside read");
  chk_fmt_read_back: assert property (s_fmt_wr ##1 s_quiet ##1 s_fmt_rd |=> rdata_out == $past(wdata_in, 3))
    else $error("format register read back wrong");
  chk_lp_clears_fmt: assert property (lowpower_in ##1 s_quiet ##1 s_fmt_rd |=> rdata_out == 8'h00)
    else $error("format register not cleared by low power");
  chk_lp_line_idle: assert property (lowpower_in |=> txd_out && sclk_out && !sclk_oe_out)
    else $error("lines not idle after low power");
  chk_idle_after_lp: assert property ($fell(lowpower_in) |-> txd_out [*3])
    else $error("transmit line left idle too soon");
  chk_sync_clk_enable: assert property (s_fmt_wr ##1 s_quiet |-> sclk_oe_out == $past(wdata_in[FB_SYNC]))
    else $error("clock enable does not follow mode bit");
  chk_async_clk_high: assert property (!sclk_oe_out |-> sclk_out)
    else $error("serial clock moved in async mode");
  chk_unmapped_zero: assert property (rd_in && addr_in > ADR_RXD |=> rdata_out == 8'h00)
    else $error("unmapped address read not zero");
endmodule : sfc_serial_chk

bind sfc_serial sfc_serial_chk #(.BIT_TICKS(BIT_TICKS)) u_chk (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .lowpower_in(lowpower_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .txd_out(txd_out),
  .rxd_in(rxd_in), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out)
);

// *** sfc_far_end.sv ***
// Far-end serial device model: sends frames and captures transmitted ones.
// Assumes the caller supplies bit times in core clocks; line idles high.
module sfc_far_end (
  input wire logic clk_in, // Core clock
  input wire logic txd_in, // Line from the block
  output logic rxd_out // Line into the block
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd_out = 1'b1;
  // Drive a prepared frame, one bit per bit time
  task automatic send_frame(input logic [11:0] v, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      rxd_out <= v[i];
      repeat (bt - 1) @(posedge clk_in);
    end
  endtask : send_frame
  // Wait for a start bit, then sample each bit at its middle
  task automatic grab(input int bt, input int n, output logic [11:0] v);
    int w;
    v = 12'h000;
    for (w = 0; w < 20000 && txd_in !== 1'b0; w++) @(negedge clk_in);
    repeat (bt / 2) @(negedge clk_in);
    for (int i = 0; i < n; i++) begin
      v[i] = txd_in;
      repeat (bt) @(negedge clk_in);
    end
  endtask : grab
endmodule : sfc_far_end

// *** serial_frame_format_config_test.sv ***
// Testbench for the serial format block with a far-end model on the line.
// Assumes sfc_serial, sfc_far_end and the bound checker are compiled first.
module serial_frame_format_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sfc_pkg::*;
  localparam logic [7:0] TICKS = 8'h04; // Short bit time
  logic core_clk_in = 1'b0, reset_in = 1'b1, lowpower_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out, r;
  logic txd_out, rxd_in, sclk_out, sclk_oe_out, s_prev;
  logic [11:0] v, got;
  int fails = 0, tests_run = 0, cyc = 0, n, bt, k;
  // Transmit rows: format value and data byte
  typedef struct packed {logic [7:0] fmt; logic [7:0] data;} sfc_row_type;
  sfc_row_type rows [10] = '{'{8'h00, 8'ha5}, '{8'h40, 8'hff}, '{8'h20, 8'h31}, '{8'h30, 8'h31},
    '{8'h38, 8'h80}, '{8'h68, 8'hc7}, '{8'h01, 8'h5a}, '{8'h02, 8'h0f}, '{8'h03, 8'h96}, '{8'h24, 8'h07}};
  always #50 core_clk_in = ~core_clk_in;
  sfc_serial #(.BIT_TICKS(TICKS)) u_dut (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .lowpower_in(lowpower_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .txd_out(txd_out), .rxd_in(rxd_in), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out));
  sfc_far_end u_far (.clk_in(core_clk_in), .txd_in(txd_out), .rxd_out(rxd_in));
  // Closing report
  task automatic end_sim;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 r = rdata_out;
  endtask : rd
  // Expected async frame: start, data LSB first, parity or mp bit, stops
  function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d, output int m);
    int nd;
    logic [11:0] w;
    nd = f[FB_SEVEN] ? 7 : 8;
    w = 12'h000;
    for (int i = 0; i < nd; i++) w[1 + i] = d[i];
    m = 1 + nd;
    if (f[FB_MP] || f[FB_PAR]) begin
      w[m] = f[FB_MP] ? 1'b0 : (^(d & (f[FB_SEVEN] ? 8'h7f : 8'hff))) ^ f[FB_ODD];
      m++;
    end
    w[m] = 1'b1;
    m += f[FB_TWO] ? 2 : 1;
    w[m - 1] = 1'b1;
    return w;
  endfunction : frame
  // Hang guard
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rd(ADR_FMT); chk(r, 12'h000);
    rd(3'h7); chk(r, 12'h000);
    // Transmit rows: format set before enable, frame checked on the line
    foreach (rows[i]) begin
      wr(ADR_CTL, 8'h00);
      wr(ADR_FMT, rows[i].fmt);
      wr(ADR_CTL, 8'h01);
      rd(ADR_FMT); chk(r, rows[i].fmt);
      v = frame(rows[i].fmt, rows[i].data, n);
      bt = int'(TICKS) << (2 * rows[i].fmt[1:0]);
      wr(ADR_TXH, rows[i].data);
      u_far.grab(bt, n, got); chk(got, v);
      repeat (bt) @(posedge core_clk_in);
    end
    // Sync mode ignores length, parity and stop bits; mp kept clear; receiver on too
    wr(ADR_CTL, 8'h00);
    wr(ADR_FMT, 8'he8);
    wr(ADR_CTL, 8'h03);
    wr(ADR_TXH, 8'h5a);
    got = 12'h000;
    k = 0;
    s_prev = 1'b1;
    for (int w = 0; w < 2000 && k < 8; w++) begin
      @(negedge core_clk_in);
      if (!s_prev && sclk_out) begin
        got[k] = txd_out;
        k++;
      end
      s_prev = sclk_out;
    end
    chk(got, 12'h05a);
    repeat (8) @(posedge core_clk_in);
    // Idle-high line shifted in on the same clocks reads back as all ones
    rd(ADR_RXD); chk(r, 12'h0ff);
    // Reception: good and bad parity for both senses
    wr(ADR_CTL, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(ADR_FMT, p ? 8'h30 : 8'h20);
      wr(ADR_CTL, 8'h02);
      wr(ADR_STA, 8'h1c);
      v = frame(p ? 8'h30 : 8'h20, 8'ha7, n);
      u_far.send_frame(v, n, 4);
      rd(ADR_RXD); chk(r, 12'h0a7);
      rd(ADR_STA); chk(r[4:2], 12'h001);
      wr(ADR_STA, 8'h1c);
      v[9] = ~v[9];
      u_far.send_frame(v, n, 4);
      rd(ADR_STA); chk(r[4:2], 12'h003);
    end
    // Two stops set, but a start right after one stop still frames
    wr(ADR_FMT, 8'h08);
    wr(ADR_STA, 8'h1c);
    v = frame(8'h00, 8'h3c, n);
    u_far.send_frame(v, n, 4);
    v = frame(8'h00, 8'hc3, n);
    u_far.send_frame(v, n, 4);
    rd(ADR_RXD); chk(r, 12'h0c3);
    rd(ADR_STA); chk(r[4:2], 12'h001);
    // Multiprocessor bit lands in status, parity setting ignored
    wr(ADR_FMT, 8'h24);
    wr(ADR_STA, 8'h1c);
    v = frame(8'h24, 8'h81, n);
    v[9] = 1'b1;
    u_far.send_frame(v, n, 4);
    rd(ADR_STA); chk(r[5:2], 12'h009);
    // Low-power entry clears the format register; mp kept clear in sync
    wr(ADR_FMT, 8'ha1);
    rd(ADR_FMT); chk(r, 12'h0a1);
    @(posedge core_clk_in);
    lowpower_in <= 1'b1;
    @(posedge core_clk_in);
    lowpower_in <= 1'b0;
    rd(ADR_FMT); chk(r, 12'h000);
    end_sim();
  end
endmodule : serial_frame_format_config_test
